/* File: pkg/modem_glue_defs.vh */
/*
 * Constants for the sixteen-port modem control glue: register indices,
 * field layout, reset values, timing and peripheral clock increments.
 * Assumes a 100 MHz APB clock; register byte address = 4 * index.
 */
`ifndef MODEM_GLUE_DEFS_VH
`define MODEM_GLUE_DEFS_VH

// Register indices (byte address is four times the index)
`define IDX_TERM_HI 32'h6000_0021
`define IDX_TERM_LO 32'h6000_0022
`define IDX_SET_HI 32'h6000_0023
`define IDX_SET_LO 32'h6000_0024
`define IDX_CTL_BASE 32'h6000_0000
`define IDX_CTL_LAST 32'h6000_001F

// Controller window index fields: [4:2] controller, [1] channel, [0] data
`define CTL_NUM_MSB 4
`define CTL_NUM_LSB 2
`define CTL_CHAN_BIT 1
`define CTL_DATA_BIT 0

// Reset values
`define TERM_RESET 16'h0000
`define BYTE_ZERO 8'h00

// Timing
`define CLK_MHZ 100
`define STRB_NS 200
`define RECOV_NS 400
`define STRB_CYC ((`STRB_NS * `CLK_MHZ + 999) / 1000)
`define RECOV_CYC ((`RECOV_NS * `CLK_MHZ + 999) / 1000)

// Phase increments: 2^32 * (2 * f_periph) / 100 MHz, toggle per wrap
`define PCLK_INC_SLOW 32'h25BF_AD29
`define PCLK_INC_FAST 32'h4B7F_5A53

`endif

/* File: src/modem_glue.v */
/*
 * Sixteen-port modem control glue: APB slave for the discrete terminal
 * ready and set ready registers, a paced access window onto eight
 * dual-channel serial controllers, modem line routing per channel,
 * DMA request routing and the controllers' peripheral clock.
 * Assumes an APB master on pclk, controllers and modem lines outside.
 */
// The APB interface to the registers was left to the implementer.
// Functional notes
// RQ1: Eight dual-channel serial controllers, two ports each, sixteen ports.
// RQ2: Controller accesses paced in hardware to meet write recovery.
// RQ3: Controllers clocked at 7.3728 MHz slow variant or 14.7456 fast.
// RQ4: Each port has its own transmit DMA and receive DMA channel.
// RQ5: Sixteen set ready inputs held in a register, read at two decodes.
// RQ6: Clear to send goes to channel A for even, B for odd ports.
// RQ7: Carrier detect goes to channel A for even, B for odd ports.
// RQ8: Sixteen terminal ready outputs driven from a register, two decodes.
// RQ9: Upper decode writes ports 15..8, lower writes 7..0; write-only.
// RQ10: Request to send comes from channel A even, channel B odd ports.
// RQ11: Receive clocks feed channel A for even, channel B for odd ports.
// RQ12: Port n maps to controller n/2, channel A even, B odd.
// RQ13: Set ready register splits ports 15..8 and 7..0 over two bytes.
`timescale 1ns/1ps
`include "modem_glue_defs.vh"

module modem_glue #(
    parameter NUM_CTL = 8,
    parameter STRB_CYC = `STRB_CYC,
    parameter RECOV_CYC = `RECOV_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire fast_variant,
    input wire [2*NUM_CTL-1:0] clear_in,
    input wire [2*NUM_CTL-1:0] carrier_in,
    input wire [2*NUM_CTL-1:0] rx_clock_in,
    input wire [2*NUM_CTL-1:0] set_ready_in,
    output reg [2*NUM_CTL-1:0] term_ready_out,
    output wire [2*NUM_CTL-1:0] request_out,
    output wire [NUM_CTL-1:0] chan_a_clear_input,
    output wire [NUM_CTL-1:0] chan_b_clear_input,
    output wire [NUM_CTL-1:0] chan_a_carrier_input,
    output wire [NUM_CTL-1:0] chan_b_carrier_input,
    output wire [NUM_CTL-1:0] chan_a_receive_clock,
    output wire [NUM_CTL-1:0] chan_b_receive_clock,
    input wire [NUM_CTL-1:0] chan_a_request_output,
    input wire [NUM_CTL-1:0] chan_b_request_output,
    input wire [2*NUM_CTL-1:0] ctl_tx_dreq,
    input wire [2*NUM_CTL-1:0] ctl_rx_dreq,
    output reg [2*NUM_CTL-1:0] dma_tx_req,
    output reg [2*NUM_CTL-1:0] dma_rx_req,
    output reg [NUM_CTL-1:0] ctl_sel_n_ff,
    output reg ctl_chan_b_ff,
    output reg ctl_data_ff,
    output reg ctl_rd_n_ff,
    output reg ctl_wr_n_ff,
    output reg [7:0] ctl_wdata_ff,
    input wire [7:0] ctl_rdata,
    output reg serial_pclk_ff
);

    localparam NP = 2 * NUM_CTL;
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_STRB = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;
    // Full indices; only their low byte reaches the decoder
    localparam [31:0] TERM_HI_IDX = `IDX_TERM_HI;
    localparam [31:0] TERM_LO_IDX = `IDX_TERM_LO;
    localparam [31:0] SET_HI_IDX = `IDX_SET_HI;
    localparam [31:0] SET_LO_IDX = `IDX_SET_LO;
    localparam [31:0] CTL_LAST_IDX = `IDX_CTL_LAST;

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [7:0] cnt_ff;
    reg [7:0] nxt_cnt;
    reg [7:0] recov_ff;
    reg [7:0] nxt_recov;
    reg [NP-1:0] set_meta_ff;
    reg [NP-1:0] set_sync_ff;
    reg [NP-1:0] set_ready_ff;
    reg [NP-1:0] txd_meta_ff;
    reg [NP-1:0] rxd_meta_ff;
    reg var_meta_ff;
    reg var_sync_ff;
    reg [31:0] phase_ff;
    wire [7:0] idx;
    wire access;
    wire hit_term_hi;
    wire hit_term_lo;
    wire hit_set_hi;
    wire hit_set_lo;
    wire hit_ctl;
    wire hit_any;
    wire ctl_go;
    wire [2:0] ctl_num;
    wire [32:0] phase_sum;

    // Partial decode: the system decoder owns the upper address bits
    assign idx = paddr[9:2];
    assign access = psel & penable;
    assign hit_term_hi = (idx == TERM_HI_IDX[7:0]);
    assign hit_term_lo = (idx == TERM_LO_IDX[7:0]);
    assign hit_set_hi = (idx == SET_HI_IDX[7:0]);
    assign hit_set_lo = (idx == SET_LO_IDX[7:0]);
    assign hit_ctl = (idx <= CTL_LAST_IDX[7:0]);
    assign hit_any = hit_term_hi | hit_term_lo | hit_set_hi | hit_set_lo
        | hit_ctl;
    assign ctl_num = idx[`CTL_NUM_MSB:`CTL_NUM_LSB]; // RQ12

    // Controller access may start only once recovery has run out
    assign ctl_go = access & hit_ctl & (state_ff == ST_IDLE)
        & (recov_ff == 8'h00); // RQ2

    // Register accesses finish at once; controller ones when paced out
    assign pready = ~(psel & hit_ctl) | (state_ff == ST_DONE);

    // Per-port routing: port n is controller n/2, even A, odd B
    genvar g;
    generate
        for (g = 0; g < NUM_CTL; g = g + 1)
        begin : g_route
            assign chan_a_clear_input[g] = clear_in[2*g]; // RQ6
            assign chan_b_clear_input[g] = clear_in[2*g+1]; // RQ6
            assign chan_a_carrier_input[g] = carrier_in[2*g]; // RQ7
            assign chan_b_carrier_input[g] = carrier_in[2*g+1]; // RQ7
            assign chan_a_receive_clock[g] = rx_clock_in[2*g]; // RQ11
            assign chan_b_receive_clock[g] = rx_clock_in[2*g+1]; // RQ11
            assign request_out[2*g] = chan_a_request_output[g]; // RQ10
            assign request_out[2*g+1] = chan_b_request_output[g]; // RQ10
        end
    endgenerate

    // Pin synchronisers; the first stage feeds only the second
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            set_meta_ff <= {NP{1'b0}};
            set_sync_ff <= {NP{1'b0}};
            set_ready_ff <= {NP{1'b0}};
            txd_meta_ff <= {NP{1'b0}};
            rxd_meta_ff <= {NP{1'b0}};
            dma_tx_req <= {NP{1'b0}};
            dma_rx_req <= {NP{1'b0}};
            var_meta_ff <= 1'b0;
            var_sync_ff <= 1'b0;
        end
        else
        begin
            set_meta_ff <= set_ready_in;
            set_sync_ff <= set_meta_ff;
            set_ready_ff <= set_sync_ff; // RQ5
            txd_meta_ff <= ctl_tx_dreq;
            rxd_meta_ff <= ctl_rx_dreq;
            dma_tx_req <= txd_meta_ff; // RQ4
            dma_rx_req <= rxd_meta_ff; // RQ4
            var_meta_ff <= fast_variant;
            var_sync_ff <= var_meta_ff;
        end
    end

    // Phase accumulator toggles the peripheral clock on each wrap.
    // Edges jitter by one pclk period; the average rate is exact.
    assign phase_sum = {1'b0, phase_ff} + (var_sync_ff ?
        {1'b0, `PCLK_INC_FAST} : {1'b0, `PCLK_INC_SLOW});

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_ff <= 32'h0000_0000;
            serial_pclk_ff <= 1'b0;
        end
        else
        begin
            phase_ff <= phase_sum[31:0];
            if (phase_sum[32])
            begin
                serial_pclk_ff <= ~serial_pclk_ff; // RQ3
            end
        end
    end

    // Controller access sequencer: strobe, then hand back to APB
    always @*
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_recov = (recov_ff != 8'h00) ? recov_ff - 8'h01 : recov_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (ctl_go)
                begin
                    nxt_state = ST_STRB;
                    nxt_cnt = STRB_CYC[7:0];
                end
            end
            ST_STRB:
            begin
                if (cnt_ff == 8'h01)
                begin
                    nxt_state = ST_DONE;
                    nxt_recov = RECOV_CYC[7:0]; // RQ2
                end
                else
                begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
            ST_DONE:
            begin
                nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= 8'h00;
            recov_ff <= 8'h00;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            recov_ff <= nxt_recov;
        end
    end

    // Controller bus pins, held steady over the whole strobe
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_sel_n_ff <= {NUM_CTL{1'b1}};
            ctl_chan_b_ff <= 1'b0;
            ctl_data_ff <= 1'b0;
            ctl_rd_n_ff <= 1'b1;
            ctl_wr_n_ff <= 1'b1;
            ctl_wdata_ff <= `BYTE_ZERO;
        end
        else if (ctl_go)
        begin
            ctl_sel_n_ff <= ~({{(NUM_CTL-1){1'b0}}, 1'b1} << ctl_num); // RQ1
            ctl_chan_b_ff <= idx[`CTL_CHAN_BIT]; // RQ12
            ctl_data_ff <= idx[`CTL_DATA_BIT];
            ctl_rd_n_ff <= pwrite;
            ctl_wr_n_ff <= ~pwrite;
            ctl_wdata_ff <= pwdata[7:0];
        end
        else if (state_ff == ST_STRB && cnt_ff == 8'h01)
        begin
            // Pins released after the last strobe cycle
            ctl_sel_n_ff <= {NUM_CTL{1'b1}};
            ctl_rd_n_ff <= 1'b1;
            ctl_wr_n_ff <= 1'b1;
        end
    end

    // Terminal ready register: two byte-wide write-only decodes
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            term_ready_out <= `TERM_RESET;
        end
        else if (access & pwrite & hit_term_hi)
        begin
            term_ready_out[15:8] <= pwdata[7:0]; // RQ8 RQ9
        end
        else if (access & pwrite & hit_term_lo)
        begin
            term_ready_out[7:0] <= pwdata[7:0]; // RQ8 RQ9
        end
    end

    // Read data and error answer; write-only locations read as zero
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel & ~penable)
        begin
            pslverr <= ~hit_any | (pwrite & (hit_set_hi | hit_set_lo));
            if (pwrite)
            begin
                prdata <= 32'h0000_0000;
            end
            else if (hit_set_hi)
            begin
                prdata <= {24'h00_0000, set_ready_ff[15:8]}; // RQ5 RQ13
            end
            else if (hit_set_lo)
            begin
                prdata <= {24'h00_0000, set_ready_ff[7:0]}; // RQ5 RQ13
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
        else if (state_ff == ST_STRB && cnt_ff == 8'h01 && ctl_rd_n_ff == 1'b0)
        begin
            prdata <= {24'h00_0000, ctl_rdata};
        end
    end

endmodule // modem_glue

/* File: tb/modem_glue_assertions.sv */
/* Port checker for the modem control glue.
   Assumes one pclk domain; bound to every modem_glue. */
`timescale 1ns/1ps
module modem_glue_assertions #(
    parameter STRB_CYC = 2,
    parameter RECOV_CYC = 2
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [15:0] clear_in,
    input wire [15:0] carrier_in,
    input wire [15:0] term_ready_out,
    input wire [15:0] request_out,
    input wire [7:0] chan_a_clear_input,
    input wire [7:0] chan_b_clear_input,
    input wire [7:0] chan_a_carrier_input,
    input wire [7:0] chan_b_carrier_input,
    input wire [7:0] chan_a_request_output,
    input wire [7:0] chan_b_request_output,
    input wire [7:0] ctl_sel_n_ff,
    input wire ctl_rd_n_ff,
    input wire ctl_wr_n_ff,
    input wire serial_pclk_ff
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg [7:0] low_ff;
    reg [7:0] gap_ff;
    wire idle = ctl_rd_n_ff & ctl_wr_n_ff;
    wire wr_go = psel & penable & pwrite & pready;
    // Even bits of a port vector, one per controller
    function automatic [7:0] ev(input [15:0] v);
        for (int i = 0; i < 8; i++)
            ev[i] = v[2*i];
    endfunction
    // Strobe length so far
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            low_ff <= 8'h00;
        else
            low_ff <= idle ? 8'h00 : low_ff + 8'h01;
    // Idle gap, saturates so a long pause never wraps to zero
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            gap_ff <= 8'hFF;
        else
            gap_ff <= !idle ? 8'h00 : (&gap_ff ? gap_ff : gap_ff + 8'h01);
    sequence pclk_high_s;
        serial_pclk_ff [*3];
    endsequence
    strobe_width_a: assert property ($rose(idle) |-> low_ff == STRB_CYC)
        else $error("controller strobe length wrong");
    recovery_gap_a: assert property ($fell(idle)
        |-> gap_ff >= RECOV_CYC)
        else $error("controller recovery too short");
    select_onehot_a: assert property ((ctl_sel_n_ff != 8'hFF) == !idle
        && $countones(~ctl_sel_n_ff) <= 1)
        else $error("controller select not one-hot with strobe");
    term_upper_a: assert property (wr_go && paddr[9:2] == 8'h21
        |=> term_ready_out[15:8] == $past(pwdata[7:0]))
        else $error("upper terminal ready byte wrong");
    term_lower_a: assert property (wr_go && paddr[9:2] == 8'h22
        |=> term_ready_out[7:0] == $past(pwdata[7:0]))
        else $error("lower terminal ready byte wrong");
    clear_route_a: assert property (chan_a_clear_input == ev(clear_in)
        && chan_b_clear_input == ev(clear_in >> 1))
        else $error("clear to send routing wrong");
    carrier_route_a: assert property (chan_a_carrier_input
        == ev(carrier_in) && chan_b_carrier_input == ev(carrier_in >> 1))
        else $error("carrier routing wrong");
    request_route_a: assert property (ev(request_out)
        == chan_a_request_output
        && ev(request_out >> 1) == chan_b_request_output)
        else $error("request to send routing wrong");
    periph_clock_a: assert property ($rose(serial_pclk_ff)
        |-> pclk_high_s ##[1:8] !serial_pclk_ff)
        else $error("peripheral clock half period wrong");
endmodule // modem_glue_assertions
bind modem_glue modem_glue_assertions #(.STRB_CYC(STRB_CYC),
    .RECOV_CYC(RECOV_CYC)) chk_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .pready, .paddr, .pwdata, .clear_in, .carrier_in,
    .term_ready_out, .request_out, .chan_a_clear_input,
    .chan_b_clear_input, .chan_a_carrier_input, .chan_b_carrier_input,
    .chan_a_request_output, .chan_b_request_output, .ctl_rd_n_ff,
    .ctl_wr_n_ff, .serial_pclk_ff, .ctl_sel_n_ff);

/* File: tb/serial_ctl_model.sv */
/* Behavioural model of the eight serial controllers.
   Assumes the glue's registered select and strobe pins. */
`timescale 1ns/1ps
module serial_ctl_model (
    input wire [7:0] ctl_sel_n_ff,
    input wire ctl_chan_b_ff,
    input wire ctl_data_ff,
    input wire ctl_rd_n_ff,
    input wire ctl_wr_n_ff,
    input wire [7:0] ctl_wdata_ff,
    output logic [7:0] ctl_rdata,
    output logic [7:0] chan_a_request_output = 8'h00,
    output logic [7:0] chan_b_request_output = 8'h00
);
    logic [2:0] num;
    logic [7:0] drv = 8'h00;
    // Selected controller number
    always @*
    begin
        num = 3'h0;
        for (int k = 0; k < 8; k++)
            if (!ctl_sel_n_ff[k])
                num = k[2:0];
    end
    // Value the selected channel drives, follows the pins while read
    always @*
        if (!ctl_rd_n_ff)
            drv = {3'h5, num, ctl_chan_b_ff, ctl_data_ff};
    // Idle bus shows the inverse, never a stale copy
    assign ctl_rdata = !ctl_rd_n_ff ? drv : ~drv;
    // Command write bit 1 drives the channel's request line
    always @*
        if (!ctl_wr_n_ff && !ctl_data_ff && !(&ctl_sel_n_ff))
            if (ctl_chan_b_ff)
                chan_b_request_output[num] = ctl_wdata_ff[1];
            else
                chan_a_request_output[num] = ctl_wdata_ff[1];
endmodule // serial_ctl_model

/* File: tb/tb.sv */
/* Self-checking bench for modem_glue with short strobe counts.
   Assumes the serial controller model on the controller pins. */
`timescale 1ns/1ps
`include "modem_glue_defs.vh"
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic fast_variant = 1, er;
    logic [31:0] paddr = 0, pwdata = 0, rd;
    logic [15:0] clear_in = 0, carrier_in = 0, rx_clock_in = 0;
    logic [15:0] set_ready_in = 16'hC35A, ctl_tx_dreq = 0, ctl_rx_dreq = 0;
    wire pready, pslverr, ctl_chan_b_ff, ctl_data_ff, ctl_rd_n_ff;
    wire ctl_wr_n_ff, serial_pclk_ff;
    wire [31:0] prdata;
    wire [15:0] term_ready_out, request_out, dma_tx_req, dma_rx_req;
    wire [7:0] chan_a_clear_input, chan_b_clear_input, ctl_sel_n_ff;
    wire [7:0] chan_a_carrier_input, chan_b_carrier_input, ctl_rdata;
    wire [7:0] chan_a_receive_clock, chan_b_receive_clock, ctl_wdata_ff;
    wire [7:0] chan_a_request_output, chan_b_request_output;
    int n_errors = 0, total_checks = 0;
    int rise_cnt;
    typedef struct {logic w; logic [31:0] i; logic [7:0] d, q; logic e;} row_t;
    row_t rows[7] = '{'{1, `IDX_TERM_HI, 8'hA5, 8'h00, 0},
        '{1, `IDX_TERM_LO, 8'h3C, 8'h00, 0}, '{0, `IDX_TERM_HI, 0, 0, 0},
        '{0, `IDX_SET_HI, 0, 8'hC3, 0}, '{0, `IDX_SET_LO, 0, 8'h5A, 0},
        '{1, `IDX_SET_HI, 8'hFF, 0, 1}, '{0, 32'h6000_0030, 0, 0, 1}};
    modem_glue #(.STRB_CYC(4), .RECOV_CYC(6)) DUT (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .fast_variant, .clear_in, .carrier_in, .rx_clock_in,
        .set_ready_in, .term_ready_out, .request_out, .chan_a_clear_input,
        .chan_b_clear_input, .chan_a_carrier_input, .chan_b_carrier_input,
        .chan_a_receive_clock, .chan_b_receive_clock,
        .chan_a_request_output, .chan_b_request_output, .ctl_tx_dreq,
        .ctl_rx_dreq, .dma_tx_req, .dma_rx_req, .ctl_sel_n_ff,
        .ctl_chan_b_ff, .ctl_data_ff, .ctl_rd_n_ff, .ctl_wr_n_ff,
        .ctl_wdata_ff, .ctl_rdata, .serial_pclk_ff);
    serial_ctl_model ctl_i (.ctl_sel_n_ff, .ctl_chan_b_ff, .ctl_data_ff,
        .ctl_rd_n_ff, .ctl_wr_n_ff, .ctl_wdata_ff, .ctl_rdata,
        .chan_a_request_output, .chan_b_request_output);
    initial forever #5 pclk = ~pclk;
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task final_report;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One APB transfer; waits on pready, a gap cycle after
    task apb(input logic w, input logic [31:0] i, input logic [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= i << 2;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        // No local limit: only the watchdog ends a wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Rising edges of the peripheral clock over 1000 pclk cycles
    task rate(output int cnt);
        logic prev;
        cnt = 0;
        prev = serial_pclk_ff;
        repeat (1000)
        begin
            @(posedge pclk);
            if (serial_pclk_ff && !prev)
                cnt++;
            prev = serial_pclk_ff;
        end
    endtask
    // Hang guard
    initial
    begin
        #200000;
        $display("Error watchdog expected finish seen timeout");
        n_errors++;
        final_report;
    end
    initial
    begin
        repeat (6) @(posedge pclk);
        chk("term reset", term_ready_out, `TERM_RESET);
        presetn <= 1;
        clear_in <= 16'h9A61;
        carrier_in <= 16'h35C6;
        rx_clock_in <= 16'h0003;
        repeat (4) @(posedge pclk);
        foreach (rows[k])
        begin
            apb(rows[k].w, rows[k].i, rows[k].d);
            if (!rows[k].w)
                chk("prdata", rd, {24'h0, rows[k].q});
            chk("pslverr", er, rows[k].e);
        end
        chk("term", term_ready_out, 16'hA53C);
        chk("rx clock", {chan_b_receive_clock, chan_a_receive_clock},
            16'h0101);
        // Back-to-back controller accesses, recovery must be inserted
        apb(1, `IDX_CTL_BASE + 6, 8'h02);
        chk("request 3", request_out, 16'h0008);
        apb(0, `IDX_CTL_BASE + 3, 8'h00);
        chk("ctl read", rd, 32'h0000_00A3);
        ctl_tx_dreq <= 16'h8001;
        ctl_rx_dreq <= 16'h0180;
        repeat (3) @(posedge pclk);
        chk("dma", {dma_tx_req, dma_rx_req}, 32'h8001_0180);
        // 14.7456 MHz over 10 us: 147.456 rising edges
        rate(rise_cnt);
        chk("fast rate", rise_cnt == 147 || rise_cnt == 148, 1'b1);
        presetn <= 0;
        fast_variant <= 0;
        @(posedge pclk);
        chk("term mid reset", term_ready_out, `TERM_RESET);
        presetn <= 1;
        // 7.3728 MHz over 10 us: 73.728 rising edges
        rate(rise_cnt);
        chk("slow rate", rise_cnt == 73 || rise_cnt == 74, 1'b1);
        apb(1, `IDX_TERM_LO, 8'h81);
        chk("term after reset", term_ready_out, 16'h0081);
        repeat (40) @(posedge pclk);
        final_report;
    end
endmodule // tb
